// file: rtl/pin_function_pkg.sv
// Package of addresses, field positions, codes and reset values for the pin function block.
package pin_function_pkg;

  // Byte addresses of the two function select registers.
  localparam logic [31:0] P0_HIGH_FN_ADDR  = 32'hE002_C004;
  localparam logic [31:0] P1_GROUP_FN_ADDR = 32'hE002_C014;

  // Byte addresses of the port 0 GPIO registers.
  localparam logic [31:0] P0_PIN_ADDR = 32'hE002_8000;
  localparam logic [31:0] P0_SET_ADDR = 32'hE002_8004;
  localparam logic [31:0] P0_DIR_ADDR = 32'hE002_8008;
  localparam logic [31:0] P0_CLR_ADDR = 32'hE002_800C;

  // Byte addresses of the port 1 GPIO registers.
  localparam logic [31:0] P1_PIN_ADDR = 32'hE002_8010;
  localparam logic [31:0] P1_SET_ADDR = 32'hE002_8014;
  localparam logic [31:0] P1_DIR_ADDR = 32'hE002_8018;
  localparam logic [31:0] P1_CLR_ADDR = 32'hE002_801C;

  // Reset values of every stored register.
  localparam logic [31:0] FN_RESET   = 32'h0000_0000;
  localparam logic [31:0] GPIO_RESET = 32'h0000_0000;

  // Implemented bits of the GPIO banks and of the port 1 group register.
  localparam logic [31:0] P0_GPIO_MASK  = 32'hFF00_0000;
  localparam logic [31:0] P1_GPIO_MASK  = 32'hFFFF_0000;
  localparam logic [31:0] P1_GROUP_MASK = 32'h0000_000C;

  // Bit positions of the port 1 group selects.
  localparam int DEBUG_SEL_BIT = 2;
  localparam int TRACE_SEL_BIT = 3;

  // Pin numbering and the field of the first handled port 0 pin.
  localparam int P0_FIRST_PIN = 24;
  localparam int P0_PINS      = 8;
  localparam int P0_FIELD_LSB = 16;
  localparam int P1_FIRST_PIN = 16;
  localparam int P1_PINS      = 16;
  localparam int TRACE_PINS   = 10;
  localparam int DEBUG_PINS   = 6;

  // Two-bit function codes of a select field.
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;

  // Codes that drive the pad as a digital output, indexed by pin minus 24.
  localparam logic [3:0] P0_DRIVE_MASK [P0_PINS] =
    '{4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h8, 4'h0, 4'h0};

endpackage

// file: rtl/gpio_bank.sv
// Direction and output storage of one GPIO port with set and clear writes.
`timescale 1ns/1ps
module gpio_bank #(
  parameter logic [31:0] MASK = 32'hFFFF_FFFF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        dir_we_i,
  input  wire logic        set_we_i,
  input  wire logic        clr_we_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  byte_en_i,
  output logic      [31:0] dir_o,
  output logic      [31:0] out_o
);
  import pin_function_pkg::*;

  logic [31:0] lane_mask;  // Written bits after byte lanes and bank mask.

  // Byte enables pick the lanes; unimplemented bits never change.
  always_comb begin
    lane_mask = {{8{byte_en_i[3]}}, {8{byte_en_i[2]}}, {8{byte_en_i[1]}}, {8{byte_en_i[0]}}} & MASK;
  end

  // Direction bits come up as inputs and load on a direction write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o <= GPIO_RESET;  // [R10]
    end else if (dir_we_i) begin
      dir_o <= (dir_o & ~lane_mask) | (wdata_i & lane_mask);
    end
  end

  // Ones in a set write raise bits, ones in a clear write lower them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= GPIO_RESET;
    end else if (set_we_i) begin
      out_o <= out_o | (wdata_i & lane_mask);  // [R11]
    end else if (clr_we_i) begin
      out_o <= out_o & ~(wdata_i & lane_mask);  // [R11]
    end
  end

endmodule

// file: rtl/pin_route_cell.sv
// Combinational route of one pad by its two-bit function select field.
`timescale 1ns/1ps
module pin_route_cell #(
  parameter logic [3:0] DRIVE_MASK = 4'h0
) (
  input  wire logic [1:0] sel_i,
  input  wire logic       gpio_dir_i,
  input  wire logic       gpio_out_i,
  input  wire logic [3:0] fn_out_i,
  output logic            oe_o,
  output logic            out_o,
  output logic      [3:0] hit_o
);
  import pin_function_pkg::*;

  // One-hot decode of the select field for the peripheral side.
  always_comb begin
    hit_o        = 4'h0;
    hit_o[sel_i] = 1'b1;
  end

  // GPIO follows software direction; other codes drive as the function needs.
  always_comb begin
    if (sel_i == FN_GPIO) begin
      oe_o  = gpio_dir_i;  // [R1]
      out_o = gpio_out_i;
    end else begin
      oe_o  = DRIVE_MASK[sel_i];  // [R2]
      out_o = fn_out_i[sel_i] & DRIVE_MASK[sel_i];
    end
  end

endmodule

// file: rtl/port_pin_function_select.sv
// Pin function multiplexer for port 0 pins 24 to 31 and port 1 groups.
//
// Functional notes
// R1: Direction bit acts only in GPIO function.
// R2: Peripheral functions set pad direction themselves.
// R3: Software never writes reserved select codes.
// R4: Group bit 2 routes P1.31:26 to debug.
// R5: Group bit 3 routes P1.25:16 to trace.
// R6: Pin 27: GPIO, channel 0, capture 1, match 1.
// R7: Pin 28: GPIO, channel 1, capture 2, match 2.
// R8: Pin 29: GPIO, channel 2, capture 3, match 3.
// R9: Pin 30: GPIO, channel 3, interrupt 3, capture 0.
// R10: All GPIO pins are inputs after reset.
// R11: Set and clear writes touch only ones.
// R12: Read output register and live pins separately.
// R13: Pins 25, 26 select channels 4, 5, DAC.
// R14: Two-bit fields, code 00 is GPIO, reset 0.
`timescale 1ns/1ps
module port_pin_function_select (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  p0_pad_in_i,
  output logic      [7:0]  p0_pad_out_o,
  output logic      [7:0]  p0_pad_oe_o,
  input  wire logic [15:0] p1_pad_in_i,
  output logic      [15:0] p1_pad_out_o,
  output logic      [15:0] p1_pad_oe_o,
  input  wire logic [3:0]  t0_match_i,
  output logic      [3:0]  t0_capture_o,
  output logic             external_interrupt_line_three_o,
  output logic      [5:0]  converter0_channel_en_o,
  output logic             dac_analog_output_en_o,
  input  wire logic [5:0]  dbg_out_i,
  input  wire logic [5:0]  dbg_oe_i,
  output logic      [5:0]  dbg_in_o,
  input  wire logic [9:0]  trace_out_i
);
  import pin_function_pkg::*;

  logic [31:0] port0_high_pin_function_r;  // Port 0 high function selects.
  logic [31:0] port1_group_function_r;     // Port 1 debug and trace selects.
  logic [31:0] p0_dir;                     // Port 0 direction bits.
  logic [31:0] p0_out;                     // Port 0 output register.
  logic [31:0] p1_dir;                     // Port 1 direction bits.
  logic [31:0] p1_out;                     // Port 1 output register.
  logic [31:0] rdata_nxt;                  // Read data for the current address.
  logic        req;                        // Bus cycle in progress.
  logic        commit;                     // Write takes effect this edge.
  logic [3:0]  p0_fn_out [P0_PINS];        // Function output values per pin.
  logic [3:0]  p0_hit [P0_PINS];           // Decoded select per pin.
  logic [7:0]  p0_oe_nxt;                  // Next port 0 output enables.
  logic [7:0]  p0_out_nxt;                 // Next port 0 pad values.
  logic [15:0] p1_oe_nxt;                  // Next port 1 output enables.
  logic [15:0] p1_out_nxt;                 // Next port 1 pad values.
  logic        debug_on;                   // Debug group owns its pins.
  logic        trace_on;                   // Trace group owns its pins.

  assign req      = cyc_i & stb_i;
  assign commit   = req & we_i & ack_o;
  assign debug_on = port1_group_function_r[DEBUG_SEL_BIT];
  assign trace_on = port1_group_function_r[TRACE_SEL_BIT];

  // Ack rises one edge after the request and falls the edge after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  // Read data is captured together with the rising ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req & ~ack_o) begin
      dat_o <= rdata_nxt;
    end
  end

  // Read decode; pin addresses show live pads, set addresses the output register.
  always_comb begin
    unique case (adr_i)
      P0_HIGH_FN_ADDR:  rdata_nxt = port0_high_pin_function_r;
      P1_GROUP_FN_ADDR: rdata_nxt = port1_group_function_r;
      P0_PIN_ADDR:      rdata_nxt = {p0_pad_in_i, 24'h00_0000};  // [R12]
      P0_SET_ADDR:      rdata_nxt = p0_out;                      // [R12]
      P0_DIR_ADDR:      rdata_nxt = p0_dir;
      P1_PIN_ADDR:      rdata_nxt = {p1_pad_in_i, 16'h0000};     // [R12]
      P1_SET_ADDR:      rdata_nxt = p1_out;                      // [R12]
      P1_DIR_ADDR:      rdata_nxt = p1_dir;
      default:          rdata_nxt = 32'h0000_0000;  // Clear and unmapped read zero.
    endcase
  end

  // Port 0 high select fields, byte-laned, all GPIO after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_high_pin_function_r <= FN_RESET;  // [R14]
    end else if (commit && adr_i == P0_HIGH_FN_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          port0_high_pin_function_r[8*b +: 8] <= dat_i[8*b +: 8];  // [R14]
        end
      end
    end
  end

  // Port 1 group selects; only bits 2 and 3 are stored, the rest read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port1_group_function_r <= FN_RESET;  // [R4] [R5]
    end else if (commit && adr_i == P1_GROUP_FN_ADDR && sel_i[0]) begin
      port1_group_function_r <= dat_i & P1_GROUP_MASK;  // [R4] [R5]
    end
  end

  // Port 0 direction and output storage.
  gpio_bank #(
    .MASK (P0_GPIO_MASK)
  ) u_p0_bank (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .dir_we_i  (commit && adr_i == P0_DIR_ADDR),
    .set_we_i  (commit && adr_i == P0_SET_ADDR),
    .clr_we_i  (commit && adr_i == P0_CLR_ADDR),
    .wdata_i   (dat_i),
    .byte_en_i (sel_i),
    .dir_o     (p0_dir),
    .out_o     (p0_out)
  );

  // Port 1 direction and output storage.
  gpio_bank #(
    .MASK (P1_GPIO_MASK)
  ) u_p1_bank (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .dir_we_i  (commit && adr_i == P1_DIR_ADDR),
    .set_we_i  (commit && adr_i == P1_SET_ADDR),
    .clr_we_i  (commit && adr_i == P1_CLR_ADDR),
    .wdata_i   (dat_i),
    .byte_en_i (sel_i),
    .dir_o     (p1_dir),
    .out_o     (p1_out)
  );

  // Timer match outputs reach pins 27 to 29 under code 11.
  always_comb begin
    for (int k = 0; k < P0_PINS; k++) begin
      p0_fn_out[k] = 4'h0;
    end
    p0_fn_out[3][FN_ALT3] = t0_match_i[1];  // [R6]
    p0_fn_out[4][FN_ALT3] = t0_match_i[2];  // [R7]
    p0_fn_out[5][FN_ALT3] = t0_match_i[3];  // [R8]
  end

  // One route cell per port 0 pin, fed by its select field.
  for (genvar i = 0; i < P0_PINS; i++) begin : g_p0
    pin_route_cell #(
      .DRIVE_MASK (P0_DRIVE_MASK[i])
    ) u_cell (
      .sel_i      (port0_high_pin_function_r[P0_FIELD_LSB + 2*i +: 2]),
      .gpio_dir_i (p0_dir[P0_FIRST_PIN + i]),
      .gpio_out_i (p0_out[P0_FIRST_PIN + i]),
      .fn_out_i   (p0_fn_out[i]),
      .oe_o       (p0_oe_nxt[i]),
      .out_o      (p0_out_nxt[i]),
      .hit_o      (p0_hit[i])
    );
  end

  // Port 1 pins: debug or trace groups take over, otherwise GPIO.
  for (genvar j = 0; j < P1_PINS; j++) begin : g_p1
    if (j >= TRACE_PINS) begin : g_dbg
      assign p1_oe_nxt[j]  = debug_on ? dbg_oe_i[j - TRACE_PINS] : p1_dir[P1_FIRST_PIN + j];   // [R4]
      assign p1_out_nxt[j] = debug_on ? dbg_out_i[j - TRACE_PINS] : p1_out[P1_FIRST_PIN + j];  // [R4]
    end else begin : g_trc
      assign p1_oe_nxt[j]  = trace_on | p1_dir[P1_FIRST_PIN + j];            // [R5]
      assign p1_out_nxt[j] = trace_on ? trace_out_i[j] : p1_out[P1_FIRST_PIN + j];  // [R5]
    end
  end

  // Pad drivers are registered; all enables are off after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p0_pad_oe_o  <= 8'h00;    // [R10]
      p0_pad_out_o <= 8'h00;
      p1_pad_oe_o  <= 16'h0000;  // [R10]
      p1_pad_out_o <= 16'h0000;
    end else begin
      p0_pad_oe_o  <= p0_oe_nxt;  // [R1] [R2]
      p0_pad_out_o <= p0_out_nxt;
      p1_pad_oe_o  <= p1_oe_nxt;
      p1_pad_out_o <= p1_out_nxt;
    end
  end

  // Pad inputs reach timer captures and the external interrupt when selected.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t0_capture_o                    <= 4'h0;
      external_interrupt_line_three_o <= 1'b0;
    end else begin
      t0_capture_o[0] <= p0_hit[6][FN_ALT3] & p0_pad_in_i[6];  // [R9]
      t0_capture_o[1] <= p0_hit[3][FN_ALT2] & p0_pad_in_i[3];  // [R6]
      t0_capture_o[2] <= p0_hit[4][FN_ALT2] & p0_pad_in_i[4];  // [R7]
      t0_capture_o[3] <= p0_hit[5][FN_ALT2] & p0_pad_in_i[5];  // [R8]
      external_interrupt_line_three_o <= p0_hit[6][FN_ALT2] & p0_pad_in_i[6];  // [R9]
    end
  end

  // Analog switch enables for converter channels and the DAC output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter0_channel_en_o <= 6'h00;
      dac_analog_output_en_o  <= 1'b0;
    end else begin
      converter0_channel_en_o[0] <= p0_hit[3][FN_ALT1];  // [R6]
      converter0_channel_en_o[1] <= p0_hit[4][FN_ALT1];  // [R7]
      converter0_channel_en_o[2] <= p0_hit[5][FN_ALT1];  // [R8]
      converter0_channel_en_o[3] <= p0_hit[6][FN_ALT1];  // [R9]
      converter0_channel_en_o[4] <= p0_hit[1][FN_ALT1];  // [R13]
      converter0_channel_en_o[5] <= p0_hit[2][FN_ALT1];  // [R13]
      dac_analog_output_en_o     <= p0_hit[1][FN_ALT2];  // [R13]
    end
  end

  // Debug port sees its pads only while the debug group is selected.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbg_in_o <= 6'h00;
    end else begin
      dbg_in_o <= p1_pad_in_i[P1_PINS-1 -: DEBUG_PINS] & {DEBUG_PINS{debug_on}};  // [R4]
    end
  end

  // Checks on the routing, all one edge after their cause.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_gpio_dir;
    (port0_high_pin_function_r[23:22] == FN_GPIO) |=> (p0_pad_oe_o[3] == $past(p0_dir[27]));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("pin 27 GPIO enable wrong");  // [R1]

  property p_match_drive;
    (port0_high_pin_function_r[25:24] == FN_ALT3)
      |=> (p0_pad_oe_o[4] && p0_pad_out_o[4] == $past(t0_match_i[2]));
  endproperty
  a_match_drive: assert property (p_match_drive) else $error("pin 28 match not driven");  // [R2]

  property p_debug;
    debug_on |=> (p1_pad_oe_o[15:10] == $past(dbg_oe_i));
  endproperty
  a_debug: assert property (p_debug) else $error("debug group enable wrong");  // [R4]

  property p_trace;
    trace_on |=> (p1_pad_oe_o[9:0] == 10'h3FF) && (p1_pad_out_o[9:0] == $past(trace_out_i));
  endproperty
  a_trace: assert property (p_trace) else $error("trace group not driven");  // [R5]

  property p_cap1;
    (port0_high_pin_function_r[23:22] == FN_ALT2) |=> (t0_capture_o[1] == $past(p0_pad_in_i[3]));
  endproperty
  a_cap1: assert property (p_cap1) else $error("capture 1 not routed");  // [R6]

  property p_eint;
    (port0_high_pin_function_r[29:28] != FN_ALT2) |=> !external_interrupt_line_three_o;
  endproperty
  a_eint: assert property (p_eint) else $error("interrupt line leaks");  // [R9]

  property p_dac;
    (port0_high_pin_function_r[19:18] == FN_ALT2) |=> dac_analog_output_en_o && !p0_pad_oe_o[1];
  endproperty
  a_dac: assert property (p_dac) else $error("DAC route wrong");  // [R13]

  property p_set;
    (commit && adr_i == P0_SET_ADDR && sel_i[3]) |=> ((p0_out[31:24] & $past(dat_i[31:24])) == $past(dat_i[31:24]));
  endproperty
  a_set: assert property (p_set) else $error("set write lost bits");  // [R11]

  // A clear write lowers only the written ones and keeps every other output bit.
  property p_clr;
    (commit && adr_i == P0_CLR_ADDR && sel_i[3])
      |=> (p0_out[31:24] == ($past(p0_out[31:24]) & ~$past(dat_i[31:24])));
  endproperty
  a_clr: assert property (p_clr) else $error("clear write changed other bits");  // [R11]

  // With the debug group off, its pins follow the GPIO direction and output bits.
  property p_debug_off;
    !debug_on
      |=> (p1_pad_oe_o[15:10] == $past(p1_dir[31:26])) && (p1_pad_out_o[15:10] == $past(p1_out[31:26]));
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug pins not back on GPIO");  // [R4]

  property p_reset;
    @(posedge clk_i) rst_i |=> (p0_pad_oe_o == 8'h00) && (p1_pad_oe_o == 16'h0000)
      && (port0_high_pin_function_r == FN_RESET);
  endproperty
  a_reset: assert property (disable iff (1'b0) p_reset) else $error("pins not inputs after reset");  // [R10]

endmodule

// file: sim/pad_env_model.sv
// Pad model that stands beyond the pin function block and resolves each pad's level.
`timescale 1ns/1ps
module pad_env_model (
  input  wire logic [7:0]  p0_out_i,
  input  wire logic [7:0]  p0_oe_i,
  input  wire logic [7:0]  p0_ext_i,
  input  wire logic [15:0] p1_out_i,
  input  wire logic [15:0] p1_oe_i,
  input  wire logic [15:0] p1_ext_i,
  output logic      [7:0]  p0_pad_o,
  output logic      [15:0] p1_pad_o
);
  // A pad the block drives shows the driven level.
  // An undriven pad shows the level that the board outside holds on it.
  assign p0_pad_o = (p0_oe_i & p0_out_i) | (~p0_oe_i & p0_ext_i);
  assign p1_pad_o = (p1_oe_i & p1_out_i) | (~p1_oe_i & p1_ext_i);
endmodule

// file: sim/tb.sv
// Self-checking testbench of the pin function block over its register bus.
`timescale 1ns/1ps
module tb;
  import pin_function_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we;   // Bus and clock drives.
  logic [31:0] adr, wdat;                    // Request address and write data.
  logic [3:0]  sel, t0_match;                // Byte lanes and timer match levels.
  logic [7:0]  p0_ext, p0_pad, p0_out, p0_oe;
  logic [15:0] p1_ext, p1_pad, p1_out, p1_oe;
  logic [5:0]  dbg_out, dbg_oe, dbg_in, conv_en;
  logic [9:0]  trace_out;
  logic [31:0] dat_o;
  logic        ack_o, external_interrupt_line_three, dac_en;
  logic [3:0]  cap;
  int          mismatches, n_checks;
  // Per-function expectations: direction, select word, pad enables, captures, analog and interrupt flags.
  logic [31:0] dirv [3] = '{32'hFF00_0000, 32'hFF00_0000, 32'h0000_0000};
  logic [31:0] fnv  [3] = '{32'h1554_0000, 32'h2A88_0000, 32'h3FC0_0000};
  logic [7:0]  oev  [3] = '{8'h81, 8'h85, 8'h38};
  logic [3:0]  capv [3] = '{4'h0, 4'hC, 4'h1};
  logic [7:0]  miscv[3] = '{8'h3F, 8'hC0, 8'h00};

  port_pin_function_select dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .p0_pad_in_i(p0_pad), .p0_pad_out_o(p0_out), .p0_pad_oe_o(p0_oe),
    .p1_pad_in_i(p1_pad), .p1_pad_out_o(p1_out), .p1_pad_oe_o(p1_oe),
    .t0_match_i(t0_match), .t0_capture_o(cap), .external_interrupt_line_three_o(external_interrupt_line_three),
    .converter0_channel_en_o(conv_en), .dac_analog_output_en_o(dac_en),
    .dbg_out_i(dbg_out), .dbg_oe_i(dbg_oe), .dbg_in_o(dbg_in), .trace_out_i(trace_out));

  pad_env_model pads_u (
    .p0_out_i(p0_out), .p0_oe_i(p0_oe), .p0_ext_i(p0_ext), .p1_out_i(p1_out),
    .p1_oe_i(p1_oe), .p1_ext_i(p1_ext), .p0_pad_o(p0_pad), .p1_pad_o(p1_pad));

  // Free-running 25 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One classic bus cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    // Let the pad outputs follow the new register contents.
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Watchdog that cuts a hung run short.
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    mismatches = 0;
    n_checks = 0;
    {cyc, stb, we, adr, wdat, sel} = '0;
    p0_ext = 8'hF0;
    p1_ext = 16'hFFFF;
    t0_match = 4'hA;
    dbg_out = 6'h2A;
    dbg_oe = 6'h15;
    trace_out = 10'h155;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state of registers and pads.
    rd(P0_HIGH_FN_ADDR, FN_RESET);
    rd(P1_GROUP_FN_ADDR, FN_RESET);
    rd(P0_DIR_ADDR, GPIO_RESET);
    rd(P1_DIR_ADDR, GPIO_RESET);
    chk(p0_oe, 8'h00);
    chk(p1_oe, 16'h0000);
    // Set and clear touch only the written ones; live pads read apart from outputs.
    wr(P0_DIR_ADDR, 32'h0800_0000);
    wr(P0_SET_ADDR, 32'h0A00_0000);
    wr(P0_CLR_ADDR, 32'h0200_0000);
    rd(P0_SET_ADDR, 32'h0800_0000);
    rd(P0_PIN_ADDR, 32'hF800_0000);
    chk(p0_oe, 8'h08);
    chk(p0_out, 8'h08);
    wr(P0_SET_ADDR, 32'h1000_0000);
    rd(P0_SET_ADDR, 32'h1800_0000);
    rd(P0_CLR_ADDR, 32'h0000_0000);
    // Every peripheral function code of pins 25 to 30, with and without direction bits.
    for (int i = 0; i < 3; i++) begin
      wr(P0_DIR_ADDR, dirv[i]);
      wr(P0_HIGH_FN_ADDR, fnv[i]);
      rd(P0_HIGH_FN_ADDR, fnv[i]);
      chk(p0_oe, oev[i]);
      chk(cap, capv[i]);
      chk({dac_en, external_interrupt_line_three, conv_en}, miscv[i]);
    end
    chk(p0_out & 8'h38, 8'h28);
    // Port 1 debug and trace groups.
    wr(P1_GROUP_FN_ADDR, 32'h0000_0004);
    chk(p1_oe, 16'h5400);
    chk(p1_out & 16'hFC00, 16'hA800);
    chk(dbg_in, 6'h2A);
    wr(P1_GROUP_FN_ADDR, 32'h0000_0008);
    rd(P1_GROUP_FN_ADDR, 32'h0000_0008);
    chk(p1_oe, 16'h03FF);
    chk(p1_out & 16'h03FF, 16'h0155);
    chk(dbg_in, 6'h00);
    // Live port 1 pads: trace drives the low ten, the undriven debug pins float high.
    rd(P1_PIN_ADDR, 32'hFD55_0000);
    wr(P1_DIR_ADDR, 32'hFFFF_0000);
    wr(P1_GROUP_FN_ADDR, 32'h0000_0000);
    chk(p1_oe, 16'hFFFF);
    // An unmapped place takes no write and reads zero.
    wr(32'hE002_C008, 32'hFFFF_FFFF);
    rd(32'hE002_C008, 32'h0000_0000);
    end_of_test();
  end
endmodule
